// file: hdl/tms_pkg.sv
// Constants, field layouts and types for the switch memory map block.
// Assumes one 40 MHz system clock and a synchronous active-high reset.
package tms_pkg;
    localparam int ADDR_W = 15;
    localparam int MEM_BIT = 14;
    localparam int INDEX_W = 14;
    localparam int STREAM_W = 5;
    localparam int CHAN_W = 9;
    localparam int DEPTH = 8192;
    localparam int WORD_W = 16;
    localparam int BYTE_W = 8;
    localparam int STREAM_HI = 13;
    localparam int STREAM_LO = 9;
    localparam int CHAN_HI = 8;
    // Route word layout
    localparam int SRC_SEL_BIT = 15;
    localparam int MSG_BIT = 14;
    localparam int ACTIVE_BIT = 13;
    localparam int FLD_STREAM_HI = 12;
    localparam int FLD_STREAM_LO = 8;
    localparam int FLD_CHAN_HI = 7;
    localparam int WIDE_STREAM_LO = 9;
    localparam int WIDE_CHAN_HI = 8;
    // Address limits
    localparam logic [4:0] WIDE_STREAM_LAST = 5'h0F;
    localparam logic [9:0] CHAN_SPAN_BASE = 10'h020;
    localparam logic [2:0] RATE_2M = 3'h0;
    localparam logic [2:0] RATE_32M = 3'h4;
    // Output and read values
    localparam logic [7:0] IDLE_HIGH_BYTE = 8'hFF;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam logic [7:0] ZERO_BYTE = 8'h00;

    typedef enum logic [1:0] {
        SEL_ROUTE = 2'h0,
        SEL_BP_RX = 2'h1,
        SEL_LOCAL_RX = 2'h2
    } tms_store_t;

    typedef enum logic [1:0] {
        HS_IDLE = 2'b01,
        HS_ANSWER = 2'b10
    } tms_host_state_t;
endpackage : tms_pkg

// file: hdl/tms_store.sv
// Flip-flop storage array with one write port and two read ports.
// Assumes writes come one per clock; reads are combinational.
`timescale 1ns/1ps
module tms_store #(
    parameter int W = 8
) (
    // Clock
    input wire logic clk,
    // Write port
    input wire logic wr_en,
    input wire logic [tms_pkg::INDEX_W-1:0] wr_index,
    input wire logic [W-1:0] wr_data,
    // Read ports
    input wire logic [tms_pkg::INDEX_W-1:0] rd_a_index,
    output logic [W-1:0] rd_a_data,
    input wire logic [tms_pkg::INDEX_W-1:0] rd_b_index,
    output logic [W-1:0] rd_b_data
);
    import tms_pkg::*;

    // Fold {stream, channel} onto 8192 rows: sixteen streams of nine
    // channel bits and thirty-two streams of eight share one layout.
    // Limitation: stream 16 and up with channel 256 and up aliases,
    // and the 32M rate (HOST_RATE 4) accepts that pair as valid.
    function automatic logic [INDEX_W-2:0] fold_row(
        input logic [INDEX_W-1:0] idx
    );
        return {idx[STREAM_HI-1:STREAM_LO], idx[STREAM_HI] | idx[CHAN_HI],
            idx[CHAN_HI-1:0]};
    endfunction : fold_row

    // Contents are traffic, so reset leaves them alone to save area
    logic [W-1:0] mem [0:DEPTH-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[fold_row(wr_index)] <= wr_data;
        end
    end

    assign rd_a_data = mem[fold_row(rd_a_index)];
    assign rd_b_data = mem[fold_row(rd_b_index)];
endmodule : tms_store

// file: hdl/tms_buffer.sv
// Two-entry buffer with valid and ready on both sides.
// Assumes the drain side may stall for any number of cycles.
`timescale 1ns/1ps
module tms_buffer #(
    parameter int W = 9,
    parameter logic [W-1:0] RESET_VALUE = '1
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    typedef struct packed {
        logic [1:0][W-1:0] entry;
        logic [1:0] fill;
    } tms_buf_state_t;

    tms_buf_state_t st;
    tms_buf_state_t next_st;
    logic push;
    logic pop;

    assign in_ready = (st.fill != 2'd2);
    assign out_valid = (st.fill != 2'd0);
    assign out_data = st.entry[0];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    always_comb begin
        next_st = st;
        if (pop) begin
            next_st.entry[0] = st.entry[1];
        end
        if (push) begin
            next_st.entry[1'(st.fill - {1'b0, pop})] = in_data;
        end
        next_st.fill = 2'(st.fill + {1'b0, push} - {1'b0, pop});
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st.entry <= {RESET_VALUE, RESET_VALUE};
            st.fill <= 2'd0;
        end else begin
            st <= next_st;
        end
    end
endmodule : tms_buffer

// file: hdl/tms_switch_map.sv
// Host address decode, receive stores and local route store of the switch.
// Assumes the host holds address and data valid while HOST_REQ is high,
// the receive side hands over one parallel byte per channel, and an outside
// register block answers REG_REQ in the same cycle on REG_RDATA.
`timescale 1ns/1ps
module tms_switch_map (
    // Clock and reset
    input wire logic SYS_CLK,
    input wire logic RESET,
    // Host access port
    input wire logic HOST_REQ,
    input wire logic HOST_WE,
    input wire logic [tms_pkg::ADDR_W-1:0] HOST_ADDR,
    input wire logic [tms_pkg::WORD_W-1:0] HOST_WDATA,
    input wire logic [1:0] HOST_STORE_SEL,
    input wire logic [2:0] HOST_RATE,
    output logic HOST_ACK,
    output logic [tms_pkg::WORD_W-1:0] HOST_RDATA,
    output logic HOST_ADDR_ERR,
    // Control register block handoff
    output logic REG_REQ,
    input wire logic [tms_pkg::WORD_W-1:0] REG_RDATA,
    // Mode straps
    input wire logic BP_WIDE_MODE,
    input wire logic LOCAL_OUTPUT_IDLE_STATE_PIN,
    // Backplane receive bytes
    input wire logic BP_RX_VALID,
    input wire logic [tms_pkg::INDEX_W-1:0] BP_RX_INDEX,
    input wire logic [tms_pkg::BYTE_W-1:0] BP_RX_DATA,
    // Local receive bytes
    input wire logic LOCAL_RX_VALID,
    input wire logic [tms_pkg::INDEX_W-1:0] LOCAL_RX_INDEX,
    input wire logic [tms_pkg::BYTE_W-1:0] LOCAL_RX_DATA,
    // Output channel requests
    input wire logic ROUTE_REQ,
    input wire logic [tms_pkg::INDEX_W-1:0] ROUTE_INDEX,
    output logic ROUTE_READY,
    // Error test source
    input wire logic BER_TX_HIT,
    input wire logic [tms_pkg::BYTE_W-1:0] BER_TX_BYTE,
    // Local serial output channel data
    output logic OUT_VALID,
    input wire logic OUT_READY,
    output logic [tms_pkg::BYTE_W-1:0] LOCAL_SERIAL_OUTPUTS_DATA,
    output logic OUT_ACTIVE,
    output logic LOCAL_SERIAL_OUTPUTS_OE,
    output logic OUT_EXT_BUF_EN
);
    import tms_pkg::*;

    typedef struct packed {
        tms_host_state_t state;
        logic ack;
        logic err;
        logic [WORD_W-1:0] rdata;
    } tms_state_t;

    tms_state_t st;
    tms_state_t next_st;

    // Host address split
    logic mem_access;
    logic [STREAM_W-1:0] host_stream;
    logic [CHAN_W-1:0] host_chan;
    logic [INDEX_W-1:0] host_index;
    logic taken;

    assign mem_access = HOST_ADDR[MEM_BIT];
    assign host_stream = HOST_ADDR[STREAM_HI:STREAM_LO];
    assign host_chan = HOST_ADDR[CHAN_HI:0];
    assign host_index = HOST_ADDR[INDEX_W-1:0];
    assign taken = HOST_REQ && (st.state == HS_IDLE);

    // Address range check
    logic [9:0] chan_span;
    logic [CHAN_W-1:0] chan_last;
    logic rate_bad;
    logic stream_bad;
    logic chan_bad;
    logic addr_bad;

    always_comb begin
        chan_span = 10'(CHAN_SPAN_BASE << HOST_RATE);
        chan_last = 9'(chan_span - 10'h001);
        rate_bad = (HOST_RATE > RATE_32M);
        chan_bad = (host_chan > chan_last);
        // Wide backplane mode has half the streams
        stream_bad = BP_WIDE_MODE && (HOST_STORE_SEL == SEL_BP_RX)
            && (host_stream > WIDE_STREAM_LAST);
        addr_bad = mem_access && (rate_bad || chan_bad || stream_bad
            || (HOST_STORE_SEL > SEL_LOCAL_RX));
    end

    // Register accesses are passed on; this block holds no registers
    assign REG_REQ = taken && !mem_access;

    // Stores
    logic route_wr;
    logic [WORD_W-1:0] route_host_word;
    logic [WORD_W-1:0] route_word;
    logic [BYTE_W-1:0] bp_host_byte;
    logic [BYTE_W-1:0] local_host_byte;
    logic [BYTE_W-1:0] bp_src_byte;
    logic [BYTE_W-1:0] local_src_byte;
    logic [INDEX_W-1:0] src_index;

    // Receive stores are read only to the host
    assign route_wr = taken && HOST_WE && mem_access && !addr_bad
        && (HOST_STORE_SEL == SEL_ROUTE);

    tms_store #(.W(BYTE_W)) u_backplane_rx_store (
        .clk(SYS_CLK),
        .wr_en(BP_RX_VALID),
        .wr_index(BP_RX_INDEX),
        .wr_data(BP_RX_DATA),
        .rd_a_index(host_index),
        .rd_a_data(bp_host_byte),
        .rd_b_index(src_index),
        .rd_b_data(bp_src_byte)
    );

    tms_store #(.W(BYTE_W)) u_local_rx_store (
        .clk(SYS_CLK),
        .wr_en(LOCAL_RX_VALID),
        .wr_index(LOCAL_RX_INDEX),
        .wr_data(LOCAL_RX_DATA),
        .rd_a_index(host_index),
        .rd_a_data(local_host_byte),
        .rd_b_index(src_index),
        .rd_b_data(local_src_byte)
    );

    tms_store #(.W(WORD_W)) u_local_route_store (
        .clk(SYS_CLK),
        .wr_en(route_wr),
        .wr_index(host_index),
        .wr_data(HOST_WDATA),
        .rd_a_index(host_index),
        .rd_a_data(route_host_word),
        .rd_b_index(ROUTE_INDEX),
        .rd_b_data(route_word)
    );

    // Host read data selection
    logic [WORD_W-1:0] mem_rdata;

    always_comb begin
        unique case (HOST_STORE_SEL)
            SEL_ROUTE: mem_rdata = route_host_word;
            SEL_BP_RX: mem_rdata = {ZERO_BYTE, bp_host_byte};
            SEL_LOCAL_RX: mem_rdata = {ZERO_BYTE, local_host_byte};
            default: mem_rdata = ZERO_WORD;
        endcase
    end

    // Host answer sequencer: take, then answer one cycle later
    always_comb begin
        next_st = st;
        next_st.ack = 1'b0;
        unique case (st.state)
            HS_IDLE: begin
                if (HOST_REQ) begin
                    next_st.state = HS_ANSWER;
                    next_st.ack = 1'b1;
                    next_st.err = addr_bad;
                    if (HOST_WE) begin
                        next_st.rdata = ZERO_WORD;
                    end else if (!mem_access) begin
                        next_st.rdata = REG_RDATA;
                    end else if (addr_bad) begin
                        next_st.rdata = ZERO_WORD;
                    end else begin
                        next_st.rdata = mem_rdata;
                    end
                end
            end
            HS_ANSWER: begin
                next_st.state = HS_IDLE;
            end
            default: begin
                next_st.state = HS_IDLE;
            end
        endcase
    end

    always_ff @(posedge SYS_CLK) begin
        if (RESET) begin
            st.state <= HS_IDLE;
            st.ack <= 1'b0;
            st.err <= 1'b0;
            st.rdata <= ZERO_WORD;
        end else begin
            st <= next_st;
        end
    end

    assign HOST_ACK = st.ack;
    assign HOST_RDATA = st.rdata;
    assign HOST_ADDR_ERR = st.err;

    // Output channel lookup
    logic src_local;
    logic msg_mode;
    logic chan_on;
    logic wide_src;
    logic [BYTE_W-1:0] push_byte;
    logic push_active;

    assign src_local = route_word[SRC_SEL_BIT];
    assign msg_mode = route_word[MSG_BIT];
    assign chan_on = route_word[ACTIVE_BIT];
    // Wide layout applies only to a backplane source in wide mode
    assign wide_src = BP_WIDE_MODE && !src_local;

    always_comb begin
        if (wide_src) begin
            src_index = {1'b0, route_word[FLD_STREAM_HI:WIDE_STREAM_LO],
                route_word[WIDE_CHAN_HI:0]};
        end else begin
            src_index = {route_word[FLD_STREAM_HI:FLD_STREAM_LO], 1'b0,
                route_word[FLD_CHAN_HI:0]};
        end
    end

    always_comb begin
        push_active = chan_on;
        if (!chan_on) begin
            push_byte = IDLE_HIGH_BYTE;
        end else if (BER_TX_HIT) begin
            push_byte = BER_TX_BYTE;
        end else if (msg_mode) begin
            // Bit 8 of a wide channel field never reaches the line
            push_byte = route_word[FLD_CHAN_HI:0];
        end else if (src_local) begin
            push_byte = local_src_byte;
        end else begin
            push_byte = bp_src_byte;
        end
    end

    // The buffer absorbs a stall so no looked-up byte is dropped
    logic [BYTE_W:0] out_item;

    tms_buffer #(
        .W(BYTE_W + 1),
        .RESET_VALUE({1'b0, IDLE_HIGH_BYTE})
    ) u_out_buffer (
        .clk(SYS_CLK),
        .rst(RESET),
        .in_valid(ROUTE_REQ),
        .in_ready(ROUTE_READY),
        .in_data({push_active, push_byte}),
        .out_valid(OUT_VALID),
        .out_ready(OUT_READY),
        .out_data(out_item)
    );

    assign LOCAL_SERIAL_OUTPUTS_DATA = out_item[BYTE_W-1:0];
    assign OUT_ACTIVE = out_item[BYTE_W] && OUT_VALID && !RESET;
    // Idle channel: pin high drives ones, pin low floats the driver
    assign LOCAL_SERIAL_OUTPUTS_OE = OUT_ACTIVE
        || LOCAL_OUTPUT_IDLE_STATE_PIN;
    assign OUT_EXT_BUF_EN = OUT_ACTIVE;

    // Checks
    logic push;
    assign push = ROUTE_REQ && ROUTE_READY;

    reg_route_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (taken && !mem_access && !HOST_WE)
        |=> HOST_RDATA == $past(REG_RDATA))
        else $error("register read data not passed to the host");

    answer_once_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        taken |=> HOST_ACK ##1 !HOST_ACK)
        else $error("host answer is not a single pulse");

    wide_stream_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (taken && mem_access && BP_WIDE_MODE
            && HOST_STORE_SEL == SEL_BP_RX && host_stream > 5'h0F)
        |=> HOST_ADDR_ERR && HOST_RDATA == ZERO_WORD)
        else $error("stream above 15 accepted in wide mode");

    chan_range_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (taken && mem_access && HOST_RATE == RATE_2M && host_chan > 9'h01F)
        |=> HOST_ADDR_ERR)
        else $error("channel above 31 accepted at the lowest rate");

    rx_upper_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (taken && mem_access && !HOST_WE && HOST_STORE_SEL != SEL_ROUTE)
        |=> HOST_RDATA[WORD_W-1:BYTE_W] == ZERO_BYTE)
        else $error("receive store read has a nonzero upper byte");

    route_back_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        route_wr |=> route_host_word == $past(HOST_WDATA)
            || host_index != $past(host_index))
        else $error("route store does not return the last written word");

    msg_byte_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (push && msg_mode && chan_on && !BER_TX_HIT && OUT_READY
            && !OUT_VALID)
        |=> OUT_VALID && LOCAL_SERIAL_OUTPUTS_DATA == $past(route_word[7:0]))
        else $error("message mode byte not sent");

    ber_keep_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (push && BER_TX_HIT && !OUT_VALID)
        |=> OUT_ACTIVE == $past(chan_on))
        else $error("error test channel lost its enable");

    idle_float_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (OUT_VALID && !OUT_ACTIVE && !LOCAL_OUTPUT_IDLE_STATE_PIN)
        |-> !LOCAL_SERIAL_OUTPUTS_OE && !OUT_EXT_BUF_EN)
        else $error("inactive channel driven with idle pin low");

    reset_out_a: assert property (
        @(posedge SYS_CLK)
        ($past(RESET) && RESET) |-> !OUT_VALID && !HOST_ACK
            && LOCAL_SERIAL_OUTPUTS_OE == LOCAL_OUTPUT_IDLE_STATE_PIN)
        else $error("outputs not idle during reset");

    src_pick_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (push && chan_on && !msg_mode && !BER_TX_HIT && !OUT_VALID)
        |=> LOCAL_SERIAL_OUTPUTS_DATA
            == $past(src_local ? local_src_byte : bp_src_byte))
        else $error("switched byte not taken from the selected store");

    idle_byte_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        (push && !chan_on && !OUT_VALID)
        |=> LOCAL_SERIAL_OUTPUTS_DATA == IDLE_HIGH_BYTE && !OUT_ACTIVE)
        else $error("inactive channel not sent as idle ones");

    ack_cause_a: assert property (
        @(posedge SYS_CLK) disable iff (RESET)
        HOST_ACK |-> $past(taken))
        else $error("host answer without a taken request");
endmodule : tms_switch_map

// file: verification/tms_far_model.sv
// Far side model: outside register block answering REG_REQ, and the
// serial output drain that can stall on command.
// Assumes the same system clock as the switch map block.
`timescale 1ns/1ps
module tms_far_model (
    // Clock
    input wire logic clk,
    // Register block handoff
    input wire logic reg_req,
    output logic [15:0] reg_rdata,
    output int reg_hits,
    // Output drain
    input wire logic stall,
    output logic out_ready
);
    localparam logic [15:0] REG_VALUE = 16'hC3E1;
    // Released lines carry the inverse so a stale sample cannot match
    assign reg_rdata = reg_req ? REG_VALUE : ~REG_VALUE;
    assign out_ready = !stall;
    always @(posedge clk) begin
        if (reg_req === 1'h1) begin
            reg_hits <= reg_hits + 1;
        end
    end
endmodule : tms_far_model

// file: verification/tms_switch_map_bench.sv
// Self-checking bench for the switch memory map block.
// Assumes tms_pkg, tms_switch_map and tms_far_model are compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin \
    n_errors++; $display("unexpected at %0t: got %h want %h", $time, \
    got, exp); end end
module tms_switch_map_bench;
    import tms_pkg::*;
    localparam logic [15:0] REG_VALUE = 16'hC3E1;
    logic SYS_CLK, RESET, HOST_REQ, HOST_WE, BP_WIDE_MODE, BP_RX_VALID;
    logic LOCAL_OUTPUT_IDLE_STATE_PIN, LOCAL_RX_VALID, ROUTE_REQ, BER_TX_HIT;
    logic OUT_READY, HOST_ACK, HOST_ADDR_ERR, REG_REQ, ROUTE_READY, OUT_VALID;
    logic OUT_ACTIVE, LOCAL_SERIAL_OUTPUTS_OE, OUT_EXT_BUF_EN, stall, er, v;
    logic [14:0] HOST_ADDR;
    logic [15:0] HOST_WDATA, HOST_RDATA, REG_RDATA, rd;
    logic [1:0] HOST_STORE_SEL;
    logic [2:0] HOST_RATE;
    logic [13:0] BP_RX_INDEX, LOCAL_RX_INDEX, ROUTE_INDEX;
    logic [7:0] BP_RX_DATA, LOCAL_RX_DATA, BER_TX_BYTE;
    logic [7:0] LOCAL_SERIAL_OUTPUTS_DATA, d;
    int n_errors = 0;
    int num_checks = 0;
    int cycles = 0;
    int reg_hits;
    // Lookup cases: route word, wide mode, test hit, idle pin, byte, active
    logic [15:0] t_word [9] = '{16'h2205, 16'hA205, 16'hE25A, 16'h0205,
        16'h6205, 16'h2405, 16'h615A, 16'hA205, 16'h0205};
    logic [7:0] t_byte [9] = '{8'hA5, 8'h3C, 8'h5A, 8'hFF, 8'h77, 8'hA5,
        8'h5A, 8'h3C, 8'hFF};
    logic [8:0] t_wide = 9'h0E0;
    logic [8:0] t_hit = 9'h110;
    logic [8:0] t_pin = 9'h088;
    logic [8:0] t_act = 9'h0F7;

    tms_switch_map uut (.SYS_CLK(SYS_CLK), .RESET(RESET),
        .HOST_REQ(HOST_REQ), .HOST_WE(HOST_WE), .HOST_ADDR(HOST_ADDR),
        .HOST_WDATA(HOST_WDATA), .HOST_STORE_SEL(HOST_STORE_SEL),
        .HOST_RATE(HOST_RATE), .HOST_ACK(HOST_ACK), .HOST_RDATA(HOST_RDATA),
        .HOST_ADDR_ERR(HOST_ADDR_ERR), .REG_REQ(REG_REQ),
        .REG_RDATA(REG_RDATA), .BP_WIDE_MODE(BP_WIDE_MODE),
        .LOCAL_OUTPUT_IDLE_STATE_PIN(LOCAL_OUTPUT_IDLE_STATE_PIN),
        .BP_RX_VALID(BP_RX_VALID), .BP_RX_INDEX(BP_RX_INDEX),
        .BP_RX_DATA(BP_RX_DATA), .LOCAL_RX_VALID(LOCAL_RX_VALID),
        .LOCAL_RX_INDEX(LOCAL_RX_INDEX), .LOCAL_RX_DATA(LOCAL_RX_DATA),
        .ROUTE_REQ(ROUTE_REQ), .ROUTE_INDEX(ROUTE_INDEX),
        .ROUTE_READY(ROUTE_READY), .BER_TX_HIT(BER_TX_HIT),
        .BER_TX_BYTE(BER_TX_BYTE), .OUT_VALID(OUT_VALID),
        .OUT_READY(OUT_READY),
        .LOCAL_SERIAL_OUTPUTS_DATA(LOCAL_SERIAL_OUTPUTS_DATA),
        .OUT_ACTIVE(OUT_ACTIVE),
        .LOCAL_SERIAL_OUTPUTS_OE(LOCAL_SERIAL_OUTPUTS_OE),
        .OUT_EXT_BUF_EN(OUT_EXT_BUF_EN));
    tms_far_model far (.clk(SYS_CLK), .reg_req(REG_REQ),
        .reg_rdata(REG_RDATA), .reg_hits(reg_hits), .stall(stall),
        .out_ready(OUT_READY));

    initial begin
        SYS_CLK = 1'h0;
        forever #12.5 SYS_CLK = ~SYS_CLK;
    end

    task final_report;
        $display("checks %0d mismatches %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : final_report

    // Whole run needs well under a thousand cycles
    always @(posedge SYS_CLK) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            $display("unexpected at %0t: timeout", $time);
            final_report();
        end
    end

    // Request held one cycle past the negedge that samples the ack, then dropped
    task host(input logic we, input logic [14:0] a, input logic [15:0] wd,
        input logic [1:0] sel, input logic [2:0] rate,
        output logic [15:0] rdv, output logic erv);
        @(negedge SYS_CLK);
        HOST_REQ = 1'h1;
        HOST_WE = we;
        HOST_ADDR = a;
        HOST_WDATA = wd;
        HOST_STORE_SEL = sel;
        HOST_RATE = rate;
        repeat (8) begin
            @(negedge SYS_CLK);
            if (HOST_ACK === 1'h1) break;
        end
        if (HOST_ACK !== 1'h1) begin
            n_errors++;
            $display("unexpected at %0t: no host answer", $time);
        end
        rdv = HOST_RDATA;
        erv = HOST_ADDR_ERR;
        @(negedge SYS_CLK);
        HOST_REQ = 1'h0;
    endtask : host

    task lookup(input logic [13:0] idx, input logic hit);
        @(negedge SYS_CLK);
        ROUTE_REQ = 1'h1;
        ROUTE_INDEX = idx;
        BER_TX_HIT = hit;
        @(negedge SYS_CLK);
        v = OUT_VALID;
        d = LOCAL_SERIAL_OUTPUTS_DATA;
        ROUTE_REQ = 1'h0;
        BER_TX_HIT = 1'h0;
    endtask : lookup

    task do_reset(input logic pin, input int n);
        @(negedge SYS_CLK);
        RESET = 1'h1;
        LOCAL_OUTPUT_IDLE_STATE_PIN = pin;
        repeat (n) @(negedge SYS_CLK);
        `CHK(OUT_ACTIVE, 1'h0);
        `CHK(LOCAL_SERIAL_OUTPUTS_OE, pin);
        `CHK(LOCAL_SERIAL_OUTPUTS_DATA, 8'hFF);
        `CHK(OUT_VALID, 1'h0);
        RESET = 1'h0;
        $display("test reset done");
    endtask : do_reset

    initial begin
        {RESET, HOST_REQ, HOST_WE, BP_WIDE_MODE, BP_RX_VALID} = 5'h10;
        {LOCAL_RX_VALID, ROUTE_REQ, BER_TX_HIT, stall} = 4'h0;
        {HOST_ADDR, HOST_WDATA, HOST_STORE_SEL, HOST_RATE} = '0;
        {BP_RX_INDEX, LOCAL_RX_INDEX, ROUTE_INDEX} = '0;
        {BP_RX_DATA, LOCAL_RX_DATA} = '0;
        BER_TX_BYTE = 8'h77;
        LOCAL_OUTPUT_IDLE_STATE_PIN = 1'h1;
        do_reset(1'h1, 20);
        host(1'h0, 15'h0002, 16'h1234, 2'h0, 3'h4, rd, er);
        `CHK(rd, REG_VALUE);
        host(1'h1, 15'h4123, 16'hBEEF, 2'h0, 3'h4, rd, er);
        host(1'h1, 15'h7FFF, 16'h1357, 2'h0, 3'h4, rd, er);
        host(1'h0, 15'h4123, 16'h0000, 2'h0, 3'h4, rd, er);
        `CHK(rd, 16'hBEEF);
        host(1'h0, 15'h7FFF, 16'h0000, 2'h0, 3'h4, rd, er);
        `CHK(rd, 16'h1357);
        `CHK(reg_hits, 1);
        $display("test host decode done");
        // Stream 2, channel 5 in both receive stores
        @(negedge SYS_CLK);
        {BP_RX_VALID, LOCAL_RX_VALID} = 2'h3;
        {BP_RX_INDEX, LOCAL_RX_INDEX} = {14'h0405, 14'h0405};
        {BP_RX_DATA, LOCAL_RX_DATA} = 16'hA53C;
        @(negedge SYS_CLK);
        {BP_RX_VALID, LOCAL_RX_VALID} = 2'h0;
        host(1'h0, 15'h4405, 16'h0000, 2'h1, 3'h0, rd, er);
        `CHK(rd, 16'h00A5);
        host(1'h0, 15'h4405, 16'h0000, 2'h2, 3'h0, rd, er);
        `CHK(rd, 16'h003C);
        host(1'h1, 15'h4405, 16'h00FF, 2'h1, 3'h0, rd, er);
        host(1'h0, 15'h4405, 16'h0000, 2'h1, 3'h0, rd, er);
        `CHK(rd, 16'h00A5);
        $display("test receive stores done");
        for (int r = 0; r < 4; r++) begin
            host(1'h0, 15'h4000 | 15'((32 << r) - 1), 16'h0000, 2'h1,
                3'(r), rd, er);
            `CHK(er, 1'h0);
            host(1'h0, 15'h4000 | 15'(32 << r), 16'h0000, 2'h1, 3'(r),
                rd, er);
            `CHK(er, 1'h1);
            `CHK(rd, 16'h0000);
        end
        host(1'h0, 15'h41FF, 16'h0000, 2'h1, 3'h4, rd, er);
        `CHK(er, 1'h0);
        host(1'h0, 15'h41FF, 16'h0000, 2'h1, 3'h5, rd, er);
        `CHK(er, 1'h1);
        host(1'h0, 15'h4000, 16'h0000, 2'h3, 3'h4, rd, er);
        `CHK(er, 1'h1);
        BP_WIDE_MODE = 1'h1;
        host(1'h0, 15'h6000, 16'h0000, 2'h1, 3'h4, rd, er);
        `CHK(er, 1'h1);
        host(1'h0, 15'h5E00, 16'h0000, 2'h1, 3'h4, rd, er);
        `CHK(er, 1'h0);
        host(1'h0, 15'h6000, 16'h0000, 2'h2, 3'h4, rd, er);
        `CHK(er, 1'h0);
        $display("test address limits done");
        for (int k = 0; k < 9; k++) begin
            BP_WIDE_MODE = t_wide[k];
            LOCAL_OUTPUT_IDLE_STATE_PIN = t_pin[k];
            host(1'h1, 15'(16'h4010 + k), t_word[k], 2'h0, 3'h4, rd, er);
            lookup(14'(16 + k), t_hit[k]);
            `CHK(v, 1'h1);
            `CHK(d, t_byte[k]);
            `CHK(OUT_ACTIVE, t_act[k]);
            `CHK(LOCAL_SERIAL_OUTPUTS_OE, t_act[k] | t_pin[k]);
            `CHK(OUT_EXT_BUF_EN, t_act[k]);
        end
        $display("test route lookups done");
        // Stalled drain: two words held, third offer refused, none lost.
        // One free cycle first lets the last lookup's byte drain.
        @(negedge SYS_CLK);
        BP_WIDE_MODE = 1'h0;
        stall = 1'h1;
        ROUTE_REQ = 1'h1;
        ROUTE_INDEX = 14'h0010;
        @(negedge SYS_CLK);
        ROUTE_INDEX = 14'h0011;
        @(negedge SYS_CLK);
        `CHK(ROUTE_READY, 1'h0);
        ROUTE_INDEX = 14'h0012;
        @(negedge SYS_CLK);
        ROUTE_REQ = 1'h0;
        `CHK(LOCAL_SERIAL_OUTPUTS_DATA, 8'hA5);
        stall = 1'h0;
        @(negedge SYS_CLK);
        `CHK(LOCAL_SERIAL_OUTPUTS_DATA, 8'h3C);
        @(negedge SYS_CLK);
        `CHK(OUT_VALID, 1'h0);
        `CHK(ROUTE_READY, 1'h1);
        $display("test buffer stall done");
        do_reset(1'h0, 2);
        final_report();
    end
endmodule : tms_switch_map_bench
